// [bench/field_model.sv]
`timescale 1ns/1ns
module field_model (
    input  wire logic CORE_CLK, SEARCH_ACTIVE, SEARCH_REVERSE,
    output logic HOME_SWITCH, FWD_LIMIT, REV_LIMIT, END_STOP, ENCODER_INDEX, ENCODER_STEP,
    output logic ENCODER_DIR
);
    logic [5:0] run = 6'h00;
    // markers come late, so the fast phase runs; slow runs only where slow and home markers differ
    always @(posedge CORE_CLK) run <= SEARCH_ACTIVE ? run + 6'h01 : 6'h00;
    assign HOME_SWITCH = run > 6'h13;
    assign END_STOP = HOME_SWITCH;
    assign FWD_LIMIT = HOME_SWITCH && !SEARCH_REVERSE;
    assign REV_LIMIT = HOME_SWITCH && SEARCH_REVERSE;
    // index only while turning, four cycles in sixteen
    assign ENCODER_INDEX = run[3] && run[2];
    // steps stop early so the synced tail cannot move the position after homing loads it
    assign ENCODER_STEP = SEARCH_ACTIVE && run < 6'h08;
    assign ENCODER_DIR = SEARCH_REVERSE;
endmodule // field_model

// [bench/homing_sequencer_monitor.sv]
`timescale 1ns/1ns
module homing_sequencer_monitor (
    input wire logic CORE_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY,
    input wire logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID,
    input wire logic S_AXI_RREADY, ENCODER_INDEX, SEARCH_ACTIVE, INDEX_OUT,
    input wire logic [1:0] S_AXI_BRESP,
    input wire logic [11:0] SEARCH_SPEED
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence wr_taken; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
    sequence rd_taken; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
    AST_WR_ANSWER: assert property (wr_taken |=> S_AXI_BVALID && S_AXI_BRESP == 2'h0)
        else $error("no write response");
    AST_RD_ANSWER: assert property (rd_taken |=> S_AXI_RVALID) else $error("no read data");
    AST_B_STANDS: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("b");
    AST_R_STANDS: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID) else $error("r");
    AST_IDLE_SPEED: assert property (!SEARCH_ACTIVE |-> SEARCH_SPEED == 12'h000)
        else $error("speed while idle");
    AST_SPEED_MAX: assert property (SEARCH_SPEED <= 12'hBB8) else $error("speed high");
    AST_INDEX_OUT: assert property ($rose(ENCODER_INDEX) |-> ##[2:4] $changed(INDEX_OUT))
        else $error("index not passed");
    AST_RUN_ENDS: assert property ($rose(SEARCH_ACTIVE) |-> ##[1:200] !SEARCH_ACTIVE)
        else $error("search did not stop");
endmodule // homing_sequencer_monitor
////////////////////////////////////////
bind homing_sequencer homing_sequencer_monitor mon (.*);

// [bench/test_homing_sequencer.sv]
`timescale 1ns/1ns
module test_homing_sequencer
    import homing_pkg::*;
;
    logic CORE_CLK = 0, RST_N = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, HOMING_START_INPUT = 0, DIVIDED_FEEDBACK = 0;
    logic REFERENCE_ECHO = 0, REFERENCE_NONZERO = 1, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
    logic S_AXI_ARREADY, S_AXI_RVALID, SEARCH_ACTIVE, SEARCH_REVERSE, PULSE_OUT, INDEX_OUT;
    logic GEAR_SELECT, IRQ, HOME_SWITCH, FWD_LIMIT, REV_LIMIT, END_STOP, ENCODER_INDEX;
    logic ENCODER_STEP, ENCODER_DIR;
    logic [7:0] S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
    logic [11:0] SEARCH_SPEED;
    int n_fail = 0, checked = 0, cycles = 0;
    homing_sequencer dut (.*);
    field_model far (.*);
    task end_sim;
        if (n_fail == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task cmp(input logic [31:0] got, exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        S_AXI_AWADDR <= a; S_AXI_WDATA <= d; S_AXI_AWVALID <= 1; S_AXI_WVALID <= 1;
        do begin
            @(posedge CORE_CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 0;
        end while (S_AXI_AWVALID && !S_AXI_AWREADY || S_AXI_WVALID && !S_AXI_WREADY);
        S_AXI_BREADY <= 1;
        do @(posedge CORE_CLK); while (!S_AXI_BVALID);
        S_AXI_BREADY <= 0;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] exp);
        S_AXI_ARADDR <= a; S_AXI_ARVALID <= 1;
        do @(posedge CORE_CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 0; S_AXI_RREADY <= 1;
        do @(posedge CORE_CLK); while (!S_AXI_RVALID);
        S_AXI_RREADY <= 0;
        cmp(S_AXI_RDATA, exp);
    endtask
    task till(input logic lvl);
        while (SEARCH_ACTIVE !== lvl) @(posedge CORE_CLK);
    endtask
    initial forever #4 CORE_CLK = ~CORE_CLK;
    // a hung handshake ends here rather than running forever
    always @(posedge CORE_CLK) if (++cycles > 20000) begin n_fail++; end_sim; end
    initial begin
        repeat (6) @(posedge CORE_CLK);
        RST_N <= 1;
        @(posedge CORE_CLK);
        rc(OFF_LOW_SPEED, 32'h64); rc(OFF_HIGH_SPEED, 32'hA);
        rc(OFF_TIME_LIMIT, 32'h2710);
        rc(OFF_INDEX_POL, 32'h1); rc(8'hFC, 32'h0);
        wr(OFF_LOW_SPEED, 32'hFA0); rc(OFF_LOW_SPEED, 32'hBB8);
        wr(OFF_HOME_OFFSET, 32'h8000_0000); rc(OFF_HOME_OFFSET, 32'hC000_0000);
        for (int i = 0; i < 3; i++) begin
            DIVIDED_FEEDBACK <= i != 1; REFERENCE_ECHO <= i != 0; wr(OFF_PULSE_SRC, i);
            repeat (3) @(posedge CORE_CLK); cmp(PULSE_OUT, i < 2);
        end
        wr(OFF_GEAR_COND, 1); wr(OFF_GEAR_REQ, 1); repeat (3) @(posedge CORE_CLK);
        cmp(GEAR_SELECT, 1); wr(OFF_GEAR_COND, 0); wr(OFF_GEAR_REQ, 0);
        repeat (20) @(posedge CORE_CLK); cmp(GEAR_SELECT, 1);
        wr(OFF_HOME_OFFSET, 5); wr(OFF_TRIGGER, TRIG_HERE); rc(OFF_POSITION, 5);
        rc(OFF_STATUS, 1); cmp(IRQ, 0); wr(OFF_OFFSET_MODE, 1); wr(OFF_TRIGGER, TRIG_OFF);
        wr(OFF_TRIGGER, TRIG_HERE); rc(OFF_POSITION, 32'hA);
        wr(OFF_STATUS, 1); wr(OFF_IRQ_MASK, 4); wr(OFF_TRIGGER, TRIG_ELEC_NOW);
        rc(OFF_POSITION, 0); rc(OFF_STATUS, 4); cmp(IRQ, 1);
        wr(OFF_STATUS, 4); rc(OFF_STATUS, 0); cmp(IRQ, 0);
        wr(OFF_HOME_OFFSET, 0); wr(OFF_OFFSET_MODE, 0); wr(OFF_TRIGGER, TRIG_OFF);
        HOMING_START_INPUT <= 1; repeat (8) @(posedge CORE_CLK); cmp(SEARCH_ACTIVE, 0);
        HOMING_START_INPUT <= 0; wr(OFF_TRIGGER, TRIG_INPUT_HOME); HOMING_START_INPUT <= 1;
        till(1); cmp(SEARCH_SPEED, 32'hA); till(0);
        HOMING_START_INPUT <= 0; rc(OFF_STATUS, 1); wr(OFF_STATUS, 1);
        for (int m = 0; m < 14; m++) begin
            wr(OFF_METHOD, m); wr(OFF_TRIGGER, TRIG_NOW); till(1);
            cmp(SEARCH_REVERSE, m % 2); till(0);
            rc(OFF_POSITION, 0); rc(OFF_STATUS, 1); wr(OFF_STATUS, 1);
        end
        end_sim;
    end
endmodule // test_homing_sequencer

// [rtl/homing_method_decode.sv]
`timescale 1ns/1ns
module homing_method_decode
    import homing_pkg::*;
(
    input  wire logic [3:0] method,
    output marker_type      slow_marker,
    output marker_type      home_marker,
    output logic            reverse
);
    always_comb begin
        reverse     = method[0];
        slow_marker = MK_HOME_SW;
        home_marker = MK_HOME_SW;
        case (method[3:1])
            3'h0: begin
                slow_marker = MK_HOME_SW;   // [R4]
                home_marker = MK_HOME_SW;
            end
            3'h1: begin
                slow_marker = MK_INDEX;     // [R5]
                home_marker = MK_INDEX;
            end
            3'h2: begin
                slow_marker = MK_HOME_SW;   // [R6]
                home_marker = MK_INDEX;
            end
            3'h3: begin
                slow_marker = MK_LIMIT;     // [R7]
                home_marker = MK_LIMIT;
            end
            3'h4: begin
                slow_marker = MK_LIMIT;     // [R8]
                home_marker = MK_INDEX;
            end
            3'h5: begin
                slow_marker = MK_END_STOP;  // [R9]
                home_marker = MK_END_STOP;
            end
            3'h6: begin
                slow_marker = MK_END_STOP;  // [R9]
                home_marker = MK_INDEX;
            end
            default: begin
                slow_marker = MK_HOME_SW;
                home_marker = MK_HOME_SW;
            end
        endcase
    end
endmodule // homing_method_decode

// [rtl/homing_pkg.sv]
package homing_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_TRIGGER     = 8'h00;
    localparam logic [7:0] OFF_METHOD      = 8'h04;
    localparam logic [7:0] OFF_LOW_SPEED   = 8'h08;
    localparam logic [7:0] OFF_HIGH_SPEED  = 8'h0C;
    localparam logic [7:0] OFF_TIME_LIMIT  = 8'h10;
    localparam logic [7:0] OFF_HOME_OFFSET = 8'h14;
    localparam logic [7:0] OFF_PULSE_SRC   = 8'h18;
    localparam logic [7:0] OFF_GEAR_COND   = 8'h1C;
    localparam logic [7:0] OFF_OFFSET_MODE = 8'h20;
    localparam logic [7:0] OFF_INDEX_POL   = 8'h24;
    localparam logic [7:0] OFF_STATUS      = 8'h28;
    localparam logic [7:0] OFF_IRQ_MASK    = 8'h2C;
    localparam logic [7:0] OFF_POSITION    = 8'h30;
    localparam logic [7:0] OFF_GEAR_REQ    = 8'h34;
    localparam logic [7:0] OFF_STATE       = 8'h38;

    // reset values
    localparam logic [2:0]  RST_TRIGGER     = 3'h0;
    localparam logic [3:0]  RST_METHOD      = 4'h0;
    localparam logic [11:0] RST_LOW_SPEED   = 12'h064;
    localparam logic [11:0] RST_HIGH_SPEED  = 12'h00A;
    localparam logic [15:0] RST_TIME_LIMIT  = 16'h2710;
    localparam logic [31:0] RST_HOME_OFFSET = 32'h0000_0000;
    localparam logic [1:0]  RST_PULSE_SRC   = 2'h0;
    localparam logic        RST_GEAR_COND   = 1'h0;
    localparam logic [1:0]  RST_OFFSET_MODE = 2'h0;
    localparam logic        RST_INDEX_POL   = 1'h1;

    // limits
    localparam logic [11:0] MAX_LOW_SPEED  = 12'hBB8;
    localparam logic [11:0] MAX_HIGH_SPEED = 12'h3E8;
    localparam logic [31:0] MAX_OFFSET     = 32'h4000_0000;
    localparam logic [31:0] MIN_OFFSET     = 32'hC000_0000;

    // timing
    localparam int CLK_HZ        = 125_000_000;
    localparam int MS_CYCLES     = CLK_HZ / 1000;
    localparam int GEAR_HOLD_US  = 2500;
    localparam int GEAR_HOLD_CYC = (CLK_HZ / 1_000_000) * GEAR_HOLD_US;

    // trigger codes
    localparam logic [2:0] TRIG_OFF        = 3'h0;
    localparam logic [2:0] TRIG_INPUT_HOME = 3'h1;
    localparam logic [2:0] TRIG_INPUT_ELEC = 3'h2;
    localparam logic [2:0] TRIG_POWER_ON   = 3'h3;
    localparam logic [2:0] TRIG_NOW        = 3'h4;
    localparam logic [2:0] TRIG_ELEC_NOW   = 3'h5;
    localparam logic [2:0] TRIG_HERE       = 3'h6;

    // status bit positions
    localparam int ST_DONE    = 0;
    localparam int ST_TIMEOUT = 1;
    localparam int ST_ELEC    = 2;

    // marker selects
    typedef enum logic [1:0] {MK_HOME_SW, MK_INDEX, MK_LIMIT, MK_END_STOP} marker_type;

endpackage

// [rtl/homing_sequencer.sv]
`timescale 1ns/1ns
// Summary of operation
// R1: trigger 0 disables; 1 homes on start input; 2 electrical home on start input.
// R2: trigger 3 homes once after reset (code: checked only right after reset, when trigger is still 0); 4 homes at once when written
// (code: no run when 4 is written while the old trigger is 0).
// R3: trigger 5 starts electrical home (code: not when 5 is written while the old trigger is 0); 6 takes present position as home.
// R4: methods 0/1 forward/reverse, home switch slows and marks home.
// R5: methods 2/3 forward/reverse, index pulse slows and marks home.
// R6: methods 4/5 slow at home switch, index pulse marks home.
// R7: method 6 forward limit switch, 7 reverse limit switch, both roles.
// R8: methods 8/9 slow at forward/reverse limit, index pulse marks home.
// R9: 10/11 end stop both roles; 12/13 slow at end stop, index home.
// R10: low speed 0..3000 rpm default 100, high 0..1000 default 10.
// R11: homing run bounded by 0..65535 ms limit, default 10000.
// R12: signed home offset within +-1073741824, default zero.
// R13: pulse source 0 divided feedback, 1 reference echo, 2 suppressed.
// R14: gear change waits 2.5 ms of zero reference under condition 0.
// R15: index output active high for 0, active low for 1.
// R16: offset modes 0/2 absolute home coordinate, 1/3 relative offset.
// R17: marker stops search, loads position, flags done; limit flags timeout.
module homing_sequencer
    import homing_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    // axi4-lite slave
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    // field pins
    input  wire logic        HOMING_START_INPUT,
    input  wire logic        HOME_SWITCH,
    input  wire logic        FWD_LIMIT,
    input  wire logic        REV_LIMIT,
    input  wire logic        END_STOP,
    input  wire logic        ENCODER_INDEX,
    input  wire logic        ENCODER_STEP,
    input  wire logic        ENCODER_DIR,
    input  wire logic        DIVIDED_FEEDBACK,
    input  wire logic        REFERENCE_ECHO,
    input  wire logic        REFERENCE_NONZERO,
    // motion outputs
    output logic             SEARCH_ACTIVE,
    output logic             SEARCH_REVERSE,
    output logic [11:0]      SEARCH_SPEED,
    output logic             PULSE_OUT,
    output logic             INDEX_OUT,
    output logic             GEAR_SELECT,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {IDLE, FAST, SLOW} phase_type;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [2:0]  homing_trigger_select;
        logic [3:0]  homing_method_select;
        logic [11:0] homing_low_speed;
        logic [11:0] homing_high_speed;
        logic [15:0] homing_time_limit;
        logic [31:0] home_offset_value;
        logic [1:0]  pulse_output_source_select;
        logic        gear_switch_condition;
        logic [1:0]  home_offset_handling_select;
        logic        index_output_polarity;
        logic [2:0]  status;
        logic [2:0]  mask;
        logic        irq;
        logic        powerup_pending;
        logic        start_prev;
        phase_type   phase;
        logic [16:0] ms_count;
        logic [16:0] ms_elapsed;
        logic [31:0] position;
        logic        gear_req;
        logic        gear_select;
        logic [18:0] zero_count;
        logic        search_reverse;
        logic [11:0] search_speed;
        logic        pulse_out;
        logic        index_out;
    } state_type;

    state_type cur;
    state_type nxt;

    logic [10:0] pins;
    marker_type  slow_marker;
    marker_type  home_marker;
    logic        reverse;

    sync2 #(
        .WIDTH (11)
    ) u_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .d     ({HOMING_START_INPUT, HOME_SWITCH, FWD_LIMIT, REV_LIMIT, END_STOP,
                 ENCODER_INDEX, ENCODER_STEP, ENCODER_DIR, DIVIDED_FEEDBACK,
                 REFERENCE_ECHO, REFERENCE_NONZERO}),
        .q     (pins)
    );

    homing_method_decode u_decode (
        .method      (cur.homing_method_select),
        .slow_marker (slow_marker),
        .home_marker (home_marker),
        .reverse     (reverse)
    );

    wire start_in  = pins[10];
    wire home_sw   = pins[9];
    wire fwd_lim   = pins[8];
    wire rev_lim   = pins[7];
    wire end_stop  = pins[6];
    wire index_in  = pins[5];
    wire enc_step  = pins[4];
    wire enc_dir   = pins[3];
    wire div_fb    = pins[2];
    wire ref_echo  = pins[1];
    wire ref_nz    = pins[0];

    ////////////////////////////////////////////////////////////////////////
    function automatic logic marker_seen(input marker_type mk, input logic rev,
                                         input logic [3:0] sw);
        // sw = {home, fwd, rev, end stop} ; index handled by caller
        case (mk)
            MK_HOME_SW:  marker_seen = sw[3];
            MK_LIMIT:    marker_seen = rev ? sw[1] : sw[2];
            MK_END_STOP: marker_seen = sw[0];
            default:     marker_seen = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    function automatic logic [11:0] clamp12(input logic [31:0] v, input logic [11:0] top);
        clamp12 = (v > {20'h0, top}) ? top : v[11:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [3:0]  sw_vec;
    logic        slow_hit;
    logic        home_hit;
    logic        do_write;
    logic        do_read;
    logic [31:0] wval;
    logic [31:0] offs;
    logic        run_req;
    logic        elec_req;
    logic        here_req;
    logic        start_rise;

    always_comb begin
        nxt        = cur;
        sw_vec     = {home_sw, fwd_lim, rev_lim, end_stop};
        slow_hit   = (slow_marker == MK_INDEX) ? index_in
                                               : marker_seen(slow_marker, reverse, sw_vec);
        home_hit   = (home_marker == MK_INDEX) ? index_in
                                               : marker_seen(home_marker, reverse, sw_vec);
        do_write   = cur.awready && cur.wready;
        do_read    = cur.arready;
        wval       = 32'h0;
        offs       = cur.home_offset_value;
        run_req    = 1'b0;
        elec_req   = 1'b0;
        here_req   = 1'b0;
        start_rise = start_in && !cur.start_prev;
        nxt.start_prev = start_in;

        // write channel: take address and data together, then answer
        nxt.awready = !cur.awready && !cur.bvalid && S_AXI_AWVALID && S_AXI_WVALID;
        nxt.wready  = nxt.awready;
        if (cur.bvalid && S_AXI_BREADY) begin
            nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            nxt.bvalid = 1'b1;
            wval = merge(32'h0, S_AXI_WDATA, S_AXI_WSTRB);
            case (S_AXI_AWADDR)
                OFF_TRIGGER: begin
                    nxt.homing_trigger_select = wval[2:0];
                    case (wval[2:0])
                        TRIG_NOW:      run_req  = 1'b1;            // [R2]
                        TRIG_ELEC_NOW: elec_req = 1'b1;            // [R3]
                        TRIG_HERE:     here_req = 1'b1;            // [R3]
                        default:       run_req  = 1'b0;
                    endcase
                end
                OFF_METHOD:     nxt.homing_method_select = (wval[3:0] > 4'hD) ? 4'hD : wval[3:0];
                OFF_LOW_SPEED:  nxt.homing_low_speed  = clamp12(wval, MAX_LOW_SPEED);  // [R10]
                OFF_HIGH_SPEED: nxt.homing_high_speed = clamp12(wval, MAX_HIGH_SPEED); // [R10]
                OFF_TIME_LIMIT: nxt.homing_time_limit = wval[15:0];                    // [R11]
                OFF_HOME_OFFSET: begin
                    wval = merge(cur.home_offset_value, S_AXI_WDATA, S_AXI_WSTRB);
                    if ($signed(wval) > $signed(MAX_OFFSET)) begin                     // [R12]
                        nxt.home_offset_value = MAX_OFFSET;
                    end else if ($signed(wval) < $signed(MIN_OFFSET)) begin
                        nxt.home_offset_value = MIN_OFFSET;
                    end else begin
                        nxt.home_offset_value = wval;
                    end
                end
                OFF_PULSE_SRC:   nxt.pulse_output_source_select = wval[1:0];
                OFF_GEAR_COND:   nxt.gear_switch_condition = wval[0];
                OFF_OFFSET_MODE: nxt.home_offset_handling_select = wval[1:0];
                OFF_INDEX_POL:   nxt.index_output_polarity = wval[0];
                OFF_STATUS:      nxt.status = cur.status & ~wval[2:0];
                OFF_IRQ_MASK:    nxt.mask = wval[2:0];
                OFF_GEAR_REQ:    nxt.gear_req = wval[0];
                default:         nxt.bvalid = 1'b1;
            endcase
        end

        // read channel
        nxt.arready = !cur.arready && !cur.rvalid && S_AXI_ARVALID;
        if (cur.rvalid && S_AXI_RREADY) begin
            nxt.rvalid = 1'b0;
        end
        if (do_read) begin
            nxt.rvalid = 1'b1;
            case (S_AXI_ARADDR)
                OFF_TRIGGER:     nxt.rdata = {29'h0, cur.homing_trigger_select};
                OFF_METHOD:      nxt.rdata = {28'h0, cur.homing_method_select};
                OFF_LOW_SPEED:   nxt.rdata = {20'h0, cur.homing_low_speed};
                OFF_HIGH_SPEED:  nxt.rdata = {20'h0, cur.homing_high_speed};
                OFF_TIME_LIMIT:  nxt.rdata = {16'h0, cur.homing_time_limit};
                OFF_HOME_OFFSET: nxt.rdata = cur.home_offset_value;
                OFF_PULSE_SRC:   nxt.rdata = {30'h0, cur.pulse_output_source_select};
                OFF_GEAR_COND:   nxt.rdata = {31'h0, cur.gear_switch_condition};
                OFF_OFFSET_MODE: nxt.rdata = {30'h0, cur.home_offset_handling_select};
                OFF_INDEX_POL:   nxt.rdata = {31'h0, cur.index_output_polarity};
                OFF_STATUS:      nxt.rdata = {29'h0, cur.status};
                OFF_IRQ_MASK:    nxt.rdata = {29'h0, cur.mask};
                OFF_POSITION:    nxt.rdata = cur.position;
                OFF_GEAR_REQ:    nxt.rdata = {30'h0, cur.gear_select, cur.gear_req};
                OFF_STATE:       nxt.rdata = {30'h0, cur.phase};
                default:         nxt.rdata = 32'h0;
            endcase
        end

        // trigger sources
        if (start_rise && cur.homing_trigger_select == TRIG_INPUT_HOME) begin
            run_req = 1'b1;                                            // [R1]
        end
        if (start_rise && cur.homing_trigger_select == TRIG_INPUT_ELEC) begin
            elec_req = 1'b1;                                           // [R1]
        end
        if (cur.powerup_pending) begin
            nxt.powerup_pending = 1'b0;
            if (cur.homing_trigger_select == TRIG_POWER_ON) begin
                run_req = 1'b1;                                        // [R2]
            end
        end
        if (cur.homing_trigger_select == TRIG_OFF) begin
            run_req  = 1'b0;                                           // [R1]
            elec_req = 1'b0;
        end

        // position counter from encoder steps
        if (enc_step) begin
            nxt.position = enc_dir ? cur.position - 32'h1 : cur.position + 32'h1;
        end

        // home offset: absolute for modes 0/2, relative for 1/3
        if (cur.home_offset_handling_select[0]) begin
            offs = cur.position + cur.home_offset_value;               // [R16]
        end

        // electrical home moves to the stored home instantly here; the drive's
        // profile generator does the physical move
        if (elec_req) begin
            nxt.position = 32'h0;
            nxt.status[ST_ELEC] = 1'b1;
        end
        if (here_req) begin
            nxt.position = offs;                                       // [R3]
            nxt.status[ST_DONE] = 1'b1;
        end

        // search sequence
        nxt.ms_count = (cur.ms_count == 17'(MS_CYCLES - 1)) ? 17'h0 : cur.ms_count + 17'h1;
        case (cur.phase)
            IDLE: begin
                if (run_req) begin
                    nxt.phase          = FAST;
                    nxt.ms_count       = 17'h0;
                    nxt.ms_elapsed     = 17'h0;
                    nxt.search_reverse = reverse;                      // [R4]
                end
            end
            FAST, SLOW: begin
                if (cur.ms_count == 17'(MS_CYCLES - 1)) begin
                    nxt.ms_elapsed = cur.ms_elapsed + 17'h1;
                end
                if (cur.phase == FAST && slow_hit) begin
                    nxt.phase = SLOW;
                end
                if (home_hit && (cur.phase == SLOW || slow_marker == home_marker)) begin
                    nxt.phase = IDLE;                                  // [R17]
                    nxt.position = offs;
                    nxt.status[ST_DONE] = 1'b1;
                end else if (cur.ms_elapsed >= {1'b0, cur.homing_time_limit}) begin
                    nxt.phase = IDLE;                                  // [R11]
                    nxt.status[ST_TIMEOUT] = 1'b1;                     // [R17]
                end
            end
            default: nxt.phase = IDLE;
        endcase
        nxt.search_speed = (nxt.phase == FAST) ? cur.homing_high_speed :
                           (nxt.phase == SLOW) ? cur.homing_low_speed : 12'h0; // [R10]

        // gear ratio switchover
        nxt.zero_count = ref_nz ? 19'h0 :
                         (cur.zero_count == 19'(GEAR_HOLD_CYC)) ? cur.zero_count
                                                                : cur.zero_count + 19'h1;
        if (cur.gear_switch_condition || cur.zero_count == 19'(GEAR_HOLD_CYC)) begin
            nxt.gear_select = cur.gear_req;                            // [R14]
        end

        // pulse output and index polarity
        case (cur.pulse_output_source_select)
            2'h0:    nxt.pulse_out = div_fb;                           // [R13]
            2'h1:    nxt.pulse_out = ref_echo;                         // [R13]
            default: nxt.pulse_out = 1'b0;                             // [R13]
        endcase
        nxt.index_out = index_in ^ cur.index_output_polarity;          // [R15]

        nxt.irq = |(nxt.status & cur.mask);
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur <= '{
                homing_trigger_select:       RST_TRIGGER,
                homing_method_select:        RST_METHOD,
                homing_low_speed:            RST_LOW_SPEED,
                homing_high_speed:           RST_HIGH_SPEED,
                homing_time_limit:           RST_TIME_LIMIT,
                home_offset_value:           RST_HOME_OFFSET,
                pulse_output_source_select:  RST_PULSE_SRC,
                gear_switch_condition:       RST_GEAR_COND,
                home_offset_handling_select: RST_OFFSET_MODE,
                index_output_polarity:       RST_INDEX_POL,
                powerup_pending:             1'b1,
                index_out:                   1'b1,
                phase:                       IDLE,
                default:                     '0
            };
        end else begin
            cur <= nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign S_AXI_AWREADY  = cur.awready;
    assign S_AXI_WREADY   = cur.wready;
    assign S_AXI_BRESP    = 2'h0;
    assign S_AXI_BVALID   = cur.bvalid;
    assign S_AXI_ARREADY  = cur.arready;
    assign S_AXI_RDATA    = cur.rdata;
    assign S_AXI_RRESP    = 2'h0;
    assign S_AXI_RVALID   = cur.rvalid;
    assign SEARCH_ACTIVE  = (cur.phase != IDLE);
    assign SEARCH_REVERSE = cur.search_reverse;
    assign SEARCH_SPEED   = cur.search_speed;
    assign PULSE_OUT      = cur.pulse_out;
    assign INDEX_OUT      = cur.index_out;
    assign GEAR_SELECT    = cur.gear_select;
    assign IRQ            = cur.irq;

endmodule // homing_sequencer

// [rtl/sync2.sv]
`timescale 1ns/1ns
module sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sync2
